// File: src/dsoh_port.sv
// One port's DS3/E3 serial overhead insertion and extraction port
`timescale 1ns/10ps
module dsoh_port
  import dsoh_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire dsoh_mode_t i_frame_mode,
  input wire dsoh_pol_t i_polarity,
  input wire logic i_loop_timed,
  input wire logic i_adapter_clock_select_bit,
  input wire logic i_tx_line_clock_in,
  input wire logic i_clock_rate_adapter_tick,
  input wire logic i_rx_recovered_tick,
  input wire dsoh_slot_t i_tx_slot,
  input wire dsoh_slot_t i_rx_slot,
  input wire logic i_tx_oh_data_in,
  input wire logic i_tx_oh_insert_enable,
  output logic o_tx_bit_tick,
  output dsoh_tx_bit_t o_tx_bit,
  output logic o_tx_oh_clock,
  output logic o_tx_oh_start_marker,
  output logic o_rx_oh_clock,
  output logic o_rx_oh_data_out,
  output logic o_rx_oh_start_marker
);

  // Pin synchronisers: the first stage feeds only the second
  logic [1:0] data_sync_r;
  logic [1:0] en_sync_r;
  logic [1:0] lclk_sync_r;
  logic lclk_prev_r;
  logic [1:0] data_sync_nxt;
  logic [1:0] en_sync_nxt;
  logic [1:0] lclk_sync_nxt;
  logic lclk_prev_nxt;

  always_comb begin
    data_sync_nxt = {data_sync_r[0], i_tx_oh_data_in};
    en_sync_nxt = {en_sync_r[0], i_tx_oh_insert_enable};
    lclk_sync_nxt = {lclk_sync_r[0], i_tx_line_clock_in};
    lclk_prev_nxt = lclk_sync_r[1];
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      data_sync_r <= 2'h0;
      en_sync_r <= 2'h0;
      lclk_sync_r <= 2'h0;
      lclk_prev_r <= 1'b0;
    end else begin
      data_sync_r <= data_sync_nxt;
      en_sync_r <= en_sync_nxt;
      lclk_sync_r <= lclk_sync_nxt;
      lclk_prev_r <= lclk_prev_nxt;
    end
  end

  logic framed;
  logic tx_data_lvl;
  logic tx_en_lvl;
  logic lclk_lvl;
  logic lclk_prev_lvl;
  logic line_edge;

  assign framed = dsoh_framed(i_frame_mode);
  assign tx_data_lvl = data_sync_r[1] ^ i_polarity.tx_data;
  assign tx_en_lvl = en_sync_r[1] ^ i_polarity.tx_en;
  assign lclk_lvl = lclk_sync_r[1] ^ i_polarity.line_clk;
  assign lclk_prev_lvl = lclk_prev_r ^ i_polarity.line_clk;
  assign line_edge = lclk_lvl && !lclk_prev_lvl;

  // Transmit bit timing source; the pin is not looked at when another source is chosen
  always_comb begin
    if (i_loop_timed) begin
      o_tx_bit_tick = i_rx_recovered_tick;
    end else if (i_adapter_clock_select_bit) begin
      o_tx_bit_tick = i_clock_rate_adapter_tick;
    end else begin
      o_tx_bit_tick = line_edge;
    end
  end

  // Transmit overhead clock, marker and merge
  logic tx_clk_r;
  logic tx_mark_r;
  logic [OH_CNT_W-1:0] tx_cnt_r;
  dsoh_tx_bit_t tx_bit_r;
  logic tx_clk_nxt;
  logic tx_mark_nxt;
  logic [OH_CNT_W-1:0] tx_cnt_nxt;
  dsoh_tx_bit_t tx_bit_nxt;
  logic tx_take;

  // Slots offered while the clock is still low are dropped: the framer spaces them wider
  assign tx_take = i_tx_slot.valid && framed && tx_clk_r;

  always_comb begin
    tx_clk_nxt = tx_clk_r;
    tx_mark_nxt = tx_mark_r;
    tx_cnt_nxt = tx_cnt_r;
    tx_bit_nxt = '0;
    if (!framed) begin
      tx_clk_nxt = 1'b1;
      tx_mark_nxt = 1'b0;
      tx_cnt_nxt = OH_CNT_ZERO;
    end else if (tx_take) begin
      tx_clk_nxt = 1'b0;
      tx_mark_nxt = i_tx_slot.first;
      tx_cnt_nxt = OH_LOW_LAST;
      tx_bit_nxt.valid = 1'b1;
      tx_bit_nxt.replaced = tx_en_lvl;
      tx_bit_nxt.value = tx_en_lvl ? tx_data_lvl : i_tx_slot.value;
    end else if (!tx_clk_r) begin
      if (tx_cnt_r == OH_CNT_ZERO) begin
        tx_clk_nxt = 1'b1;
      end else begin
        tx_cnt_nxt = tx_cnt_r - OH_CNT_ONE;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      tx_clk_r <= 1'b1;
      tx_mark_r <= 1'b0;
      tx_cnt_r <= OH_CNT_ZERO;
      tx_bit_r <= '0;
    end else begin
      tx_clk_r <= tx_clk_nxt;
      tx_mark_r <= tx_mark_nxt;
      tx_cnt_r <= tx_cnt_nxt;
      tx_bit_r <= tx_bit_nxt;
    end
  end

  // Receive overhead clock, data and marker
  logic rx_clk_r;
  logic rx_data_r;
  logic rx_mark_r;
  logic [OH_CNT_W-1:0] rx_cnt_r;
  logic rx_clk_nxt;
  logic rx_data_nxt;
  logic rx_mark_nxt;
  logic [OH_CNT_W-1:0] rx_cnt_nxt;
  logic rx_take;

  // Every overhead slot offered in a framing mode while the clock is high is passed, C-bits included even in M23
  assign rx_take = i_rx_slot.valid && framed && rx_clk_r;

  always_comb begin
    rx_clk_nxt = rx_clk_r;
    rx_data_nxt = rx_data_r;
    rx_mark_nxt = rx_mark_r;
    rx_cnt_nxt = rx_cnt_r;
    if (!framed) begin
      rx_clk_nxt = 1'b1;
      rx_mark_nxt = 1'b0;
      rx_data_nxt = 1'b0;
      rx_cnt_nxt = OH_CNT_ZERO;
    end else if (rx_take) begin
      rx_clk_nxt = 1'b0;
      rx_data_nxt = i_rx_slot.value;
      rx_mark_nxt = i_rx_slot.first;
      rx_cnt_nxt = OH_LOW_LAST;
    end else if (!rx_clk_r) begin
      if (rx_cnt_r == OH_CNT_ZERO) begin
        rx_clk_nxt = 1'b1;
      end else begin
        rx_cnt_nxt = rx_cnt_r - OH_CNT_ONE;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rx_clk_r <= 1'b1;
      rx_data_r <= 1'b0;
      rx_mark_r <= 1'b0;
      rx_cnt_r <= OH_CNT_ZERO;
    end else begin
      rx_clk_r <= rx_clk_nxt;
      rx_data_r <= rx_data_nxt;
      rx_mark_r <= rx_mark_nxt;
      rx_cnt_r <= rx_cnt_nxt;
    end
  end

  // Pin polarity; the framer-side word never sees inversion
  assign o_tx_bit = tx_bit_r;
  assign o_tx_oh_clock = tx_clk_r ^ i_polarity.tx_clk;
  assign o_tx_oh_start_marker = tx_mark_r ^ i_polarity.tx_mark;
  assign o_rx_oh_clock = rx_clk_r ^ i_polarity.rx_clk;
  assign o_rx_oh_data_out = rx_data_r ^ i_polarity.rx_data;
  assign o_rx_oh_start_marker = rx_mark_r ^ i_polarity.rx_mark;

  default clocking dsoh_cb @(posedge i_clk);
  endclocking
  default disable iff (!i_reset_n);

  a_tx_idle_inactive: assert property (!framed |=> tx_clk_r && !tx_mark_r && !o_tx_bit.valid)
    else $error("transmit overhead port active outside framing mode");

  a_tx_fall_take: assert property (tx_take |=> !tx_clk_r && o_tx_bit.valid)
    else $error("transmit overhead clock did not fall on a taken slot");

  a_tx_low_phase: assert property (tx_take ##1 framed [*8] |=>
      tx_clk_r && !$past(tx_clk_r) && !$past(tx_clk_r, 8))
    else $error("transmit overhead clock low phase has wrong length");

  a_tx_first_mark: assert property (tx_take |=> tx_mark_r == $past(i_tx_slot.first))
    else $error("transmit marker does not follow the first slot");

  a_tx_merge_sel: assert property (tx_take |=> o_tx_bit.value == ($past(tx_en_lvl) ?
      $past(tx_data_lvl) : $past(i_tx_slot.value)))
    else $error("transmit overhead bit merge chose the wrong source");

  a_tx_pin_pol: assert property (tx_take |=> o_tx_oh_clock == i_polarity.tx_clk &&
      o_tx_oh_start_marker == ($past(i_tx_slot.first) ^ i_polarity.tx_mark))
    else $error("transmit pin polarity wrong");

  a_rx_data_update: assert property (rx_take |=> !rx_clk_r && rx_data_r == $past(i_rx_slot.value))
    else $error("receive overhead data not updated at clock fall");

  a_rx_mark_first: assert property (rx_take && i_rx_slot.first |=> rx_mark_r ##1 (rx_mark_r || !framed))
    else $error("receive marker missing for first overhead bit");

  a_rx_hold_low: assert property ($fell(rx_clk_r) && framed |=> $stable(rx_data_r) [*3])
    else $error("receive overhead data moved during low phase");

  a_line_src: assert property ((i_loop_timed || i_adapter_clock_select_bit) |->
      o_tx_bit_tick == (i_loop_timed ? i_rx_recovered_tick : i_clock_rate_adapter_tick))
    else $error("line clock input used while another source is chosen");

  // Transmit side: one merged bit per fall, clock only falls on a taken slot
  a_tx_bit_pulse: assert property (o_tx_bit.valid |=> !o_tx_bit.valid)
    else $error("transmit overhead bit handed over twice in a row");

  a_tx_keep_gen: assert property (tx_take && !tx_en_lvl |=> !o_tx_bit.replaced &&
      o_tx_bit.value == $past(i_tx_slot.value))
    else $error("transmit framing bit replaced without insert enable");

  a_tx_use_ext: assert property (tx_take && tx_en_lvl |=> o_tx_bit.replaced &&
      o_tx_bit.value == $past(tx_data_lvl))
    else $error("transmit framing bit not replaced under insert enable");

  a_tx_mark_hold: assert property (framed && !tx_take |=> $stable(tx_mark_r))
    else $error("transmit marker moved without a taken slot");

  a_tx_refuse_low: assert property (i_tx_slot.valid && !tx_clk_r |=> !o_tx_bit.valid)
    else $error("transmit slot taken while overhead clock low");

  a_tx_high_hold: assert property (tx_clk_r && !tx_take |=> tx_clk_r)
    else $error("transmit overhead clock fell without a taken slot");

  // The counter only runs while the clock is low, so a high clock means zero
  a_tx_cnt_idle: assert property (tx_clk_r |-> tx_cnt_r == OH_CNT_ZERO)
    else $error("transmit low phase counter busy while clock high");

  a_tx_cnt_range: assert property (tx_cnt_r <= OH_LOW_LAST)
    else $error("transmit low phase counter out of range");

  // Receive side mirrors the transmit timing
  a_rx_idle_inactive: assert property (!framed |=> rx_clk_r && !rx_mark_r && !rx_data_r)
    else $error("receive overhead port active outside framing mode");

  a_rx_low_phase: assert property (rx_take ##1 framed [*8] |=>
      rx_clk_r && !$past(rx_clk_r) && !$past(rx_clk_r, 8))
    else $error("receive overhead clock low phase has wrong length");

  a_rx_hold_state: assert property (framed && !rx_take |=> $stable(rx_mark_r) && $stable(rx_data_r))
    else $error("receive data or marker moved without a taken slot");

  a_rx_pin_pol: assert property (rx_take |=> o_rx_oh_clock == i_polarity.rx_clk &&
      o_rx_oh_data_out == ($past(i_rx_slot.value) ^ i_polarity.rx_data) &&
      o_rx_oh_start_marker == ($past(i_rx_slot.first) ^ i_polarity.rx_mark))
    else $error("receive pin polarity wrong");

  a_rx_high_hold: assert property (rx_clk_r && !rx_take |=> rx_clk_r)
    else $error("receive overhead clock fell without a taken slot");

  a_rx_refuse_low: assert property (i_rx_slot.valid && !rx_clk_r && framed |=> $stable(rx_data_r))
    else $error("receive slot taken while overhead clock low");

  a_rx_cnt_idle: assert property (rx_clk_r |-> rx_cnt_r == OH_CNT_ZERO)
    else $error("receive low phase counter busy while clock high");

  a_rx_cnt_range: assert property (rx_cnt_r <= OH_LOW_LAST)
    else $error("receive low phase counter out of range");

  // Checked on the synchronised level, so a pin edge shows up two cycles late
  a_line_default: assert property (o_tx_bit_tick && !i_loop_timed && !i_adapter_clock_select_bit |->
      $rose(lclk_lvl))
    else $error("transmit bit tick without a line clock edge");

  c_tx_first_insert: cover property (tx_take && i_tx_slot.first && tx_en_lvl);
  c_rx_first: cover property (rx_take && i_rx_slot.first);
  c_rx_m23: cover property (rx_take && i_frame_mode == DSOH_MODE_T3_M23);
  c_adapter_src: cover property (i_adapter_clock_select_bit && !i_loop_timed && i_clock_rate_adapter_tick);
  c_tx_inverted: cover property (tx_take && i_polarity.tx_clk);

endmodule : dsoh_port

// File: src/dsoh_pkg.sv
// Constants, types and helpers for the DS3/E3 serial overhead port
//
// Contract
// - Transmit overhead port works only in DS3 or E3 framing modes, timed by its clock.
// - Per-bit insert enable picks which transmit overhead bits take the external data.
// - At each transmit overhead clock fall, sample data and enable, update marker.
// - Transmit marker is high for the first X, FAS or FA1 overhead bit.
// - Transmit sequence begins on the falling edge where the marker is high.
// - Received overhead bits go out serially in DS3 or E3 framing modes.
// - In M23 mode the C-bits still appear on the receive overhead output.
// - Receive data and marker update on each receive overhead clock fall.
// - Receive marker is high for the first X, FAS or FA1 overhead bit.
// - Receive sequence begins on the falling edge where the marker is high.
// - Each overhead clock is a low-rate clock paced by overhead bits only.
// - Every overhead port signal, clocks included, has its own polarity inversion.
// - Line clock input is ignored in loop timing or when the adapter clock is selected.
// - By default the line clock input times the transmit side.
// - A framing bit is replaced only when insert enable is active for it.
// - Overwritable bits are T3 X,P,M,F,C; G.751 FAS,RAI,national; G.832 overhead bytes.
package dsoh_pkg;

  localparam int unsigned CLK_PERIOD_NS = 8;
  // Low phase of each overhead clock after its falling edge
  localparam int unsigned OH_LOW_NS = 64;
  localparam int unsigned OH_LOW_CYC = (OH_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned OH_CNT_W = 4;
  localparam logic [OH_CNT_W-1:0] OH_LOW_LAST = OH_CNT_W'(OH_LOW_CYC - 1);
  localparam logic [OH_CNT_W-1:0] OH_CNT_ZERO = 4'h0;
  localparam logic [OH_CNT_W-1:0] OH_CNT_ONE = 4'h1;

  typedef enum logic [2:0] {
    DSOH_MODE_OFF,
    DSOH_MODE_T3_CBIT,
    DSOH_MODE_T3_M23,
    DSOH_MODE_G751,
    DSOH_MODE_G832,
    DSOH_MODE_CLEAR
  } dsoh_mode_t;

  // One bit per port signal; 1 inverts that pin
  typedef struct packed {
    logic tx_clk;
    logic tx_data;
    logic tx_en;
    logic tx_mark;
    logic rx_clk;
    logic rx_data;
    logic rx_mark;
    logic line_clk;
  } dsoh_pol_t;

  // Overhead slot offered by the framer core
  typedef struct packed {
    logic valid;
    logic first;
    logic value;
  } dsoh_slot_t;

  // Merged transmit overhead bit handed back to the framer core
  typedef struct packed {
    logic valid;
    logic value;
    logic replaced;
  } dsoh_tx_bit_t;

  function automatic logic dsoh_framed(input dsoh_mode_t mode);
    return (mode == DSOH_MODE_T3_CBIT) || (mode == DSOH_MODE_T3_M23) ||
           (mode == DSOH_MODE_G751) || (mode == DSOH_MODE_G832);
  endfunction : dsoh_framed

endpackage : dsoh_pkg

// File: tb/dsoh_ext_model.sv
// Model of the external overhead logic beside one port
`timescale 1ns/10ps
module dsoh_ext_model
  import dsoh_pkg::*;
(
  input wire dsoh_pol_t i_pol,
  input wire logic i_tx_clk,
  input wire logic i_tx_mark,
  input wire logic i_rx_clk,
  input wire logic i_rx_data,
  input wire logic i_rx_mark,
  input wire logic i_next_data,
  input wire logic i_next_en,
  output logic o_tx_data,
  output logic o_tx_en,
  output logic o_tx_mark_seen,
  output logic o_rx_data_seen,
  output logic o_rx_mark_seen
);
  logic data_r = 1'b0;
  logic en_r = 1'b0;
  wire logic tx_rise = i_tx_clk ^ i_pol.tx_clk;
  wire logic rx_rise = i_rx_clk ^ i_pol.rx_clk;
  // These pins are never released, so there is no idle level to model
  assign o_tx_data = data_r ^ i_pol.tx_data;
  assign o_tx_en = en_r ^ i_pol.tx_en;
  initial {o_tx_mark_seen, o_rx_data_seen, o_rx_mark_seen} = 3'h0;
  always @(posedge tx_rise) begin
    data_r <= i_next_data;
    en_r <= i_next_en;
    o_tx_mark_seen <= i_tx_mark ^ i_pol.tx_mark;
  end
  always @(posedge rx_rise) begin
    o_rx_data_seen <= i_rx_data ^ i_pol.rx_data;
    o_rx_mark_seen <= i_rx_mark ^ i_pol.rx_mark;
  end
endmodule : dsoh_ext_model

// File: tb/dsoh_port_tb_top.sv
// Self-checking bench for one overhead port
`timescale 1ns/10ps
module dsoh_port_tb_top
  import dsoh_pkg::*;
;
  logic i_clk = 1'b0;
  logic i_reset_n = 1'b0;
  dsoh_mode_t mode = DSOH_MODE_OFF;
  dsoh_pol_t pol = '0;
  logic loop_t = 1'b0, adp_sel = 1'b0, line_clk = 1'b0, lc_run = 1'b0;
  logic adp_tick = 1'b0, rec_tick = 1'b0, nxt_d = 1'b0, nxt_en = 1'b0;
  dsoh_slot_t tx_s = '0, rx_s = '0;
  logic oh_d, oh_en, tick, txc, txm, rxc, rxd, rxm, m_seen, d_seen, rm_seen;
  dsoh_tx_bit_t txb;
  int error_cnt = 0, samples_checked = 0, ticks = 0, cyc = 0;
  dsoh_mode_t fm [4] = '{DSOH_MODE_T3_CBIT, DSOH_MODE_T3_M23, DSOH_MODE_G751, DSOH_MODE_G832};

  dsoh_port dut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_frame_mode(mode), .i_polarity(pol),
    .i_loop_timed(loop_t), .i_adapter_clock_select_bit(adp_sel), .i_tx_line_clock_in(line_clk),
    .i_clock_rate_adapter_tick(adp_tick), .i_rx_recovered_tick(rec_tick), .i_tx_slot(tx_s),
    .i_rx_slot(rx_s), .i_tx_oh_data_in(oh_d), .i_tx_oh_insert_enable(oh_en), .o_tx_bit_tick(tick),
    .o_tx_bit(txb), .o_tx_oh_clock(txc), .o_tx_oh_start_marker(txm), .o_rx_oh_clock(rxc),
    .o_rx_oh_data_out(rxd), .o_rx_oh_start_marker(rxm));
  dsoh_ext_model ext (.i_pol(pol), .i_tx_clk(txc), .i_tx_mark(txm), .i_rx_clk(rxc), .i_rx_data(rxd),
    .i_rx_mark(rxm), .i_next_data(nxt_d), .i_next_en(nxt_en), .o_tx_data(oh_d), .o_tx_en(oh_en),
    .o_tx_mark_seen(m_seen), .o_rx_data_seen(d_seen), .o_rx_mark_seen(rm_seen));

  initial forever #4 i_clk = ~i_clk;
  // Line clock free-runs once lc_run is set, 64 ns period (8 i_clk cycles), 3 ns after the i_clk falling edges
  initial begin
    #3;
    forever #32 line_clk = lc_run ? ~line_clk : line_clk;
  end
  always @(posedge i_clk) if (tick === 1'b1) ticks <= ticks + 1;
  // Framer-side timing pulses at fixed rates, so each source gives a known count
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    rec_tick <= (cyc % 16) == 0;
    adp_tick <= (cyc % 10) == 5;
  end

  task automatic chk(input string what, input logic [2:0] exp, input logic [2:0] got);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic send_tx(input logic first, input logic gen);
    @(posedge i_clk) tx_s <= '{1'b1, first, gen};
    @(posedge i_clk) tx_s <= '0;
    #1;
  endtask : send_tx

  // A dummy slot lets the partner load this bit's data at the clock rise
  task automatic tx_bit(input logic first, input logic gen, input logic d, input logic en);
    nxt_d = d;
    nxt_en = en;
    send_tx(1'b0, ~gen);
    repeat (12) @(posedge i_clk);
    send_tx(first, gen);
    chk("tx bit", {1'b1, en ? d : gen, en}, txb);
    chk("tx pins", {1'b0, pol.tx_clk, first ^ pol.tx_mark}, {1'b0, txc, txm});
    repeat (12) @(posedge i_clk);
    chk("partner marker", {2'b0, first}, {2'b0, m_seen});
  endtask : tx_bit

  task automatic rx_bit(input logic first, input logic val);
    @(posedge i_clk) rx_s <= '{1'b1, first, val};
    @(posedge i_clk) rx_s <= '0;
    #1;
    chk("rx pins", {pol.rx_clk, val ^ pol.rx_data, first ^ pol.rx_mark}, {rxc, rxd, rxm});
    repeat (7) @(posedge i_clk);
    #1;
    chk("rx clock low", {2'b0, pol.rx_clk}, {2'b0, rxc});
    @(posedge i_clk);
    #1;
    chk("rx clock high", {1'b0, ~pol.rx_clk, 1'b0}, {1'b0, rxc, 1'b0});
    chk("partner rx", {1'b0, val, first}, {1'b0, d_seen, rm_seen});
    repeat (3) @(posedge i_clk);
  endtask : rx_bit

  task automatic framed_modes();
    foreach (fm[i]) begin
      @(posedge i_clk) mode <= fm[i];
      tx_bit(1'b1, 1'b0, 1'b1, 1'b1);
      tx_bit(1'b0, 1'b1, 1'b0, 1'b1);
      tx_bit(1'b0, 1'b1, 1'b0, 1'b0);
      rx_bit(1'b1, 1'b1);
      rx_bit(1'b0, 1'b0);
    end
  endtask : framed_modes

  task automatic refused_slots();
    send_tx(1'b1, 1'b0);
    repeat (2) @(posedge i_clk);
    send_tx(1'b0, 1'b1);
    chk("slot while low", 3'h0, txb);
    repeat (12) @(posedge i_clk);
    @(posedge i_clk) mode <= DSOH_MODE_CLEAR;
    send_tx(1'b1, 1'b1);
    chk("unframed tx", {1'b0, ~pol.tx_clk, pol.tx_mark}, {txb.valid, txc, txm});
    @(posedge i_clk) rx_s <= '{1'b1, 1'b1, 1'b1};
    @(posedge i_clk) rx_s <= '0;
    #1;
    chk("unframed rx", {~pol.rx_clk, pol.rx_data, pol.rx_mark}, {rxc, rxd, rxm});
  endtask : refused_slots

  task automatic line_clock(input logic lp, input logic adp, input int lo, input int hi);
    int t0;
    @(posedge i_clk) {loop_t, adp_sel} <= {lp, adp};
    lc_run = 1'b1;
    t0 = ticks;
    #1280;
    chk("line ticks", 3'h1, {2'b0, (ticks - t0 >= lo) && (ticks - t0 <= hi)});
  endtask : line_clock

  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : summarize

  initial begin
    #50000;
    error_cnt++;
    summarize();
  end

  initial begin
    repeat (3) @(posedge i_clk);
    i_reset_n <= 1'b1;
    framed_modes();
    @(posedge i_clk) pol <= '1;
    tx_bit(1'b1, 1'b1, 1'b0, 1'b1);
    rx_bit(1'b1, 1'b0);
    @(posedge i_clk) pol <= '0;
    refused_slots();
    line_clock(1'b0, 1'b0, 19, 21);
    line_clock(1'b1, 1'b0, 9, 11);
    line_clock(1'b0, 1'b1, 15, 17);
    summarize();
  end
endmodule : dsoh_port_tb_top
